//--- rtl/ssn_pkg.sv
// shared constants and types of the string/multiply/negate/invert datapath
// assumes one core clock and a synchronous active-low reset in every user
package ssn_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MEM_DEPTH = 64;
  localparam int MEM_AW = 6;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_EXT = 8'h0c;
  localparam logic [7:0] OFS_SRC = 8'h10;
  localparam logic [7:0] OFS_DST = 8'h14;
  localparam logic [7:0] OFS_CNT = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_MADDR = 8'h20;
  localparam logic [7:0] OFS_MDATA = 8'h24;

  // field positions and masks
  localparam int CTRL_BUSY_BIT = 8;
  localparam logic [15:0] FLAGS_WR_MASK = 16'h0fd5;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // pointer steps and bus answers
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [MEM_AW-1:0] MEM_NEXT = 6'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {OP_IDLE, OP_COPY, OP_MUL, OP_NEG, OP_NOT} ssn_op_t;

  typedef enum logic {ST_IDLE, ST_EXEC} ssn_state_t;

  typedef struct packed {
    logic iterate_prefix;
    logic word;
    ssn_op_t op;
  } ssn_cmd_t;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic overflow_flag;
    logic direction_flag;
    logic interrupt_enable_flag;
    logic trap_flag;
    logic sign_flag;
    logic zero_flag;
    logic rsv5;
    logic aux_carry_flag;
    logic rsv3;
    logic parity_flag;
    logic rsv1;
    logic carry_flag;
  } ssn_flags_t;

endpackage

//--- rtl/ssn_neg.sv
// two's complement of a W-bit value with the flags of the final increment
// assumes W of at least 8; parity looks at the low byte only
`timescale 1ns/100ps
module ssn_neg #(
  parameter int W = 8
) (
  input wire logic [W-1:0] x, // operand
  output logic [W-1:0] y, // zero minus operand
  output logic cf, // carry out of the increment
  output logic af, // carry out of bit 3
  output logic of, // signed overflow
  output logic zf, // result is zero
  output logic sf, // result sign
  output logic pf // even parity of low byte
);

  logic [W:0] sum;
  logic [4:0] low;

  always_comb
  begin
    // ones complement then plus one
    sum = {1'b0, ~x} + {{W{1'b0}}, 1'b1};
    low = {1'b0, ~x[3:0]} + 5'h01;
    y = sum[W-1:0];
    cf = sum[W];
    af = low[4];
    // only the most negative value overflows and comes back unchanged
    of = x[W-1] & y[W-1];
    zf = (y == '0);
    sf = y[W-1];
    pf = ~^y[7:0];
  end

endmodule

//--- rtl/ssn_mul.sv
// unsigned byte or word multiplier with upper-half-nonzero indication
// assumes operands are taken straight from the accumulator and operand registers
`timescale 1ns/100ps
module ssn_mul (
  input wire logic [15:0] a, // source operand
  input wire logic [15:0] b, // accumulator
  input wire logic word, // word size when high
  output logic [31:0] prod, // double-length product
  output logic hi_nz // upper half nonzero
);

  always_comb
  begin
    // RL5: zero extended operands
    if (word)
    begin
      prod = {16'h0000, a} * {16'h0000, b};
      hi_nz = |prod[31:16];
    end
    else
    begin
      prod = {16'h0000, ({8'h00, a[7:0]} * {8'h00, b[7:0]})};
      hi_nz = |prod[15:8];
    end
  end

endmodule

//--- rtl/ssn_core.sv
// datapath for string copy, unsigned multiply, negate, invert and idle,
// with its register file and element memory behind an AXI4-Lite slave
// assumes a single master, one write and one read under way at a time
//
// How it works
// RL1: copy moves a byte or word from source index to dest pointer, steps both
// RL2: with iterate prefix the element copy repeats as a block copy
// RL3: byte multiply uses acc low byte, full 16-bit product lands in acc word
// RL4: word multiply uses acc word, upper half to extension, lower to acc
// RL5: both multiply operands are unsigned with no sign extension
// RL6: multiply sets carry and overflow when the upper half is nonzero, else clears
// RL7: multiply may spoil aux, parity, sign, zero; keeps direction, interrupt, trap
// RL8: negate is ones complement plus one, flags from that addition
// RL9: negating zero gives zero with sign unchanged; the core clears sign and sets carry instead
// RL10: negating the most negative value leaves it and sets overflow
// RL11: negate updates the six arithmetic flags, keeps direction, interrupt, trap
// RL12: idle changes no register, memory or flag
// RL13: invert forms the ones complement and leaves every flag
// RL14: pointers count up with direction clear and down with it set
// RL15: pointers step by one for bytes and two for words
// RL16: copy keeps flags; repeated copy counts down and stops at zero
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module ssn_core
  import ssn_pkg::*;
(
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, ignored
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, ignored
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // bus state
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic wr_fire, wr_ok, wr_hit, rd_hit;
  logic [DATA_W-1:0] rd_val;

  // datapath state
  ssn_state_t state_r, state_nxt;
  ssn_cmd_t cmd_r, cmd_nxt;
  ssn_flags_t flg_r, flg_nxt;
  logic [15:0] opnd_r, opnd_nxt, acc_r, acc_nxt, ext_r, ext_nxt;
  logic [15:0] src_r, src_nxt, dst_r, dst_nxt, cnt_r, cnt_nxt;
  logic [MEM_AW-1:0] maddr_r, maddr_nxt;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [7:0] mem_nxt [MEM_DEPTH];
  logic [15:0] step;
  logic [MEM_AW-1:0] sidx, didx;

  // arithmetic results
  logic [31:0] prod;
  logic hi_nz;
  logic [7:0] nb_y;
  logic [15:0] nw_y;
  logic nb_cf, nb_af, nb_of, nb_zf, nb_sf, nb_pf;
  logic nw_cf, nw_af, nw_of, nw_zf, nw_sf, nw_pf;
  ssn_mul u_mul (
    .a(opnd_r),
    .b(acc_r),
    .word(cmd_r.word),
    .prod(prod),
    .hi_nz(hi_nz)
  );
  ssn_neg #(.W(8)) u_neg_byte (
    .x(opnd_r[7:0]),
    .y(nb_y),
    .cf(nb_cf),
    .af(nb_af),
    .of(nb_of),
    .zf(nb_zf),
    .sf(nb_sf),
    .pf(nb_pf)
  );
  ssn_neg #(.W(16)) u_neg_word (
    .x(opnd_r),
    .y(nw_y),
    .cf(nw_cf),
    .af(nw_af),
    .of(nw_of),
    .zf(nw_zf),
    .sf(nw_sf),
    .pf(nw_pf)
  );

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res[7:0] = strb[0] ? data[7:0] : old[7:0];
    res[15:8] = strb[1] ? data[15:8] : old[15:8];
    return res;
  endfunction
  function automatic logic map_hit(input logic [ADDR_W-1:0] addr);
    return (addr == OFS_CTRL) || (addr == OFS_OPND) || (addr == OFS_ACC) ||
           (addr == OFS_EXT) || (addr == OFS_SRC) || (addr == OFS_DST) ||
           (addr == OFS_CNT) || (addr == OFS_FLAGS) || (addr == OFS_MADDR) ||
           (addr == OFS_MDATA);
  endfunction
  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  always_comb
  begin
    rd_hit = map_hit(s_axi_araddr);
    case (s_axi_araddr)
      OFS_CTRL: rd_val = {23'h000000, (state_r == ST_EXEC), 3'h0, cmd_r};
      OFS_OPND: rd_val = {16'h0000, opnd_r};
      OFS_ACC: rd_val = {16'h0000, acc_r};
      OFS_EXT: rd_val = {16'h0000, ext_r};
      OFS_SRC: rd_val = {16'h0000, src_r};
      OFS_DST: rd_val = {16'h0000, dst_r};
      OFS_CNT: rd_val = {16'h0000, cnt_r};
      OFS_FLAGS: rd_val = {16'h0000, flg_r};
      OFS_MADDR: rd_val = {26'h0000000, maddr_r};
      OFS_MDATA: rd_val = {24'h000000, mem_r[maddr_r]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    // address and data both held: commit and answer
    wr_fire = aw_hold_r & w_hold_r;
    wr_hit = map_hit(awaddr_r);
    // writes are refused while an operation runs
    wr_ok = wr_fire & wr_hit & (state_r == ST_IDLE);
    if (wr_fire)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_val;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    flg_nxt = flg_r;
    opnd_nxt = opnd_r;
    acc_nxt = acc_r;
    ext_nxt = ext_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    cnt_nxt = cnt_r;
    maddr_nxt = maddr_r;
    mem_nxt = mem_r;
    // RL15: element size sets the step
    step = cmd_r.word ? STEP_WORD : STEP_BYTE;
    sidx = src_r[MEM_AW-1:0];
    didx = dst_r[MEM_AW-1:0];
    if (wr_ok)
    begin
      case (awaddr_r)
        OFS_CTRL:
          if (wstrb_r[0])
          begin
            cmd_nxt = ssn_cmd_t'(wdata_r[4:0]);
            state_nxt = ST_EXEC;
          end
        OFS_OPND: opnd_nxt = merge16(opnd_r, wdata_r, wstrb_r);
        OFS_ACC: acc_nxt = merge16(acc_r, wdata_r, wstrb_r);
        OFS_EXT: ext_nxt = merge16(ext_r, wdata_r, wstrb_r);
        OFS_SRC: src_nxt = merge16(src_r, wdata_r, wstrb_r);
        OFS_DST: dst_nxt = merge16(dst_r, wdata_r, wstrb_r);
        OFS_CNT: cnt_nxt = merge16(cnt_r, wdata_r, wstrb_r);
        OFS_FLAGS: flg_nxt = ssn_flags_t'(merge16(flg_r, wdata_r, wstrb_r) & FLAGS_WR_MASK);
        OFS_MADDR:
          if (wstrb_r[0])
          begin
            maddr_nxt = wdata_r[MEM_AW-1:0];
          end
        OFS_MDATA:
          if (wstrb_r[0])
          begin
            mem_nxt[maddr_r] = wdata_r[7:0];
          end
        default: ;
      endcase
    end
    if (state_r == ST_EXEC)
    begin
      state_nxt = ST_IDLE;
      case (cmd_r.op)
        // RL12: nothing changes
        OP_IDLE: ;
        OP_COPY:
        begin
          // RL16: empty count copies nothing
          if (!cmd_r.iterate_prefix || (cnt_r != 16'h0000))
          begin
            // RL1: one element moved
            mem_nxt[didx] = mem_r[sidx];
            if (cmd_r.word)
            begin
              mem_nxt[didx + MEM_NEXT] = mem_r[sidx + MEM_NEXT];
            end
            // RL14: direction picks up or down
            src_nxt = flg_r.direction_flag ? (src_r - step) : (src_r + step);
            dst_nxt = flg_r.direction_flag ? (dst_r - step) : (dst_r + step);
            // RL2: repeat until count exhausted
            if (cmd_r.iterate_prefix)
            begin
              // RL16: count down per element
              cnt_nxt = cnt_r - 16'h0001;
              state_nxt = (cnt_r == 16'h0001) ? ST_IDLE : ST_EXEC;
            end
          end
        end
        OP_MUL:
        begin
          // RL3: low product half into acc word
          acc_nxt = prod[15:0];
          // RL4: word upper half to extension
          ext_nxt = cmd_r.word ? prod[31:16] : ext_r;
          // RL6: upper half drives carry and overflow
          flg_nxt.carry_flag = hi_nz;
          flg_nxt.overflow_flag = hi_nz;
          // RL7: remaining flags are simply kept
        end
        OP_NEG:
        begin
          // RL8: increment of ones complement
          // RL9: zero stays zero
          // RL10: most negative stays and overflows
          // RL11: six arithmetic flags from the result
          opnd_nxt = cmd_r.word ? nw_y : {opnd_r[15:8], nb_y};
          flg_nxt.carry_flag = cmd_r.word ? nw_cf : nb_cf;
          flg_nxt.aux_carry_flag = cmd_r.word ? nw_af : nb_af;
          flg_nxt.overflow_flag = cmd_r.word ? nw_of : nb_of;
          flg_nxt.zero_flag = cmd_r.word ? nw_zf : nb_zf;
          flg_nxt.sign_flag = cmd_r.word ? nw_sf : nb_sf;
          flg_nxt.parity_flag = cmd_r.word ? nw_pf : nb_pf;
        end
        // RL13: ones complement, flags kept
        OP_NOT: opnd_nxt = cmd_r.word ? ~opnd_r : {opnd_r[15:8], ~opnd_r[7:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      cmd_r <= ssn_cmd_t'(5'h00);
      flg_r <= ssn_flags_t'(RST_FLAGS);
      opnd_r <= RST_WORD;
      acc_r <= RST_WORD;
      ext_r <= RST_WORD;
      src_r <= RST_WORD;
      dst_r <= RST_WORD;
      cnt_r <= RST_WORD;
      maddr_r <= '0;
      for (int i = 0; i < MEM_DEPTH; i++)
      begin
        mem_r[i] <= RST_BYTE;
      end
    end
    else
    begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      flg_r <= flg_nxt;
      opnd_r <= opnd_nxt;
      acc_r <= acc_nxt;
      ext_r <= ext_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      cnt_r <= cnt_nxt;
      maddr_r <= maddr_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule

//--- verification/ssn_core_asserts.sv
// bus-level checks on the ports of the datapath core
// assumes it is bound to ssn_core and sees only that module's ports
`timescale 1ns/100ps
module ssn_core_asserts
  import ssn_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // aw
  input wire logic [2:0] s_axi_awprot, // aw
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic [DATA_W-1:0] s_axi_wdata, // w
  input wire logic [3:0] s_axi_wstrb, // w
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic [1:0] s_axi_bresp, // b
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic [ADDR_W-1:0] s_axi_araddr, // ar
  input wire logic [2:0] s_axi_arprot, // ar
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [DATA_W-1:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp, // r
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready // r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  AST_AR_READY: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read address ready wrong");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h27
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  COV_WR_ERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  COV_RD_ERR: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  COV_WR_OK: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
endmodule

bind ssn_core ssn_core_asserts u_ssn_core_asserts (.*);

//--- verification/ssn_core_tb.sv
// self-checking bench for the copy, multiply, negate, invert and idle core
// assumes the core's register map and AXI4-Lite timing at a 25 MHz clock
`timescale 1ns/100ps
module ssn_core_tb;
  import ssn_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int error_cnt = 0;
  int cmp_count = 0;

  ssn_core u_ssn_core (.*);

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'b0;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] v);
    logic [1:0] r;
    wr(a, {16'h0, v}, r);
  endtask

  task automatic ck(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask

  // wait for idle, start, wait again; the command must read back
  task automatic run(input logic [4:0] c);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h100;
    while (d[CTRL_BUSY_BIT])
      rd(OFS_CTRL, d, r);
    wr(OFS_CTRL, {27'h0, c}, r);
    chk_resp("ctrl wr", RESP_OKAY, r);
    d = 32'h100;
    while (d[CTRL_BUSY_BIT])
      rd(OFS_CTRL, d, r);
    chk("ctrl", {27'h0, c}, d);
  endtask

  task automatic mw(input logic [5:0] a, input logic [7:0] v);
    wreg(OFS_MADDR, {10'h0, a});
    wreg(OFS_MDATA, {8'h0, v});
  endtask

  task automatic mck(input logic [5:0] a, input logic [7:0] v);
    wreg(OFS_MADDR, {10'h0, a});
    ck(OFS_MDATA, {24'h0, v}, "mem");
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    ck(OFS_ACC, 32'h0, "acc reset");
    ck(OFS_FLAGS, 32'h0, "flags reset");
    wr(8'h40, 32'h1234, r);
    chk_resp("unmapped wr", RESP_SLVERR, r);
    wr(8'h06, 32'h1234, r);
    chk_resp("unaligned wr", RESP_SLVERR, r);
    rd(8'h80, d, r);
    chk_resp("unmapped rd", RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    wreg(OFS_FLAGS, 16'hffff);
    ck(OFS_FLAGS, {16'h0, FLAGS_WR_MASK}, "flags mask");
  endtask

  task automatic t_mul();
    logic [15:0] ov[4] = '{16'h00ff, 16'h0003, 16'hffff, 16'h0100};
    logic [15:0] av[4] = '{16'h12ff, 16'h0005, 16'h0002, 16'h0010};
    logic [15:0] ea[4] = '{16'hfe01, 16'h000f, 16'hfffe, 16'h1000};
    logic [15:0] ee[4] = '{16'h5555, 16'h5555, 16'h0001, 16'h0000};
    logic [15:0] ef[4] = '{16'h0f01, 16'h0700, 16'h0f01, 16'h0700};
    for (int i = 0; i < 4; i++)
    begin
      wreg(OFS_FLAGS, 16'h0700);
      wreg(OFS_EXT, 16'h5555);
      wreg(OFS_OPND, ov[i]);
      wreg(OFS_ACC, av[i]);
      run({1'b0, i[1], OP_MUL});
      ck(OFS_ACC, {16'h0, ea[i]}, "mul acc");
      ck(OFS_EXT, {16'h0, ee[i]}, "mul ext");
      ck(OFS_FLAGS, {16'h0, ef[i]}, "mul flags");
    end
  endtask

  task automatic t_neg();
    logic [15:0] ov[5] = '{16'h1201, 16'h3400, 16'h0080, 16'h8000, 16'h0005};
    logic [15:0] er[5] = '{16'h12ff, 16'h3400, 16'h0080, 16'h8000, 16'hfffb};
    logic [15:0] ef[5] = '{16'h0784, 16'h0755, 16'h0f90, 16'h0f94, 16'h0780};
    for (int i = 0; i < 5; i++)
    begin
      wreg(OFS_FLAGS, 16'h0700);
      wreg(OFS_OPND, ov[i]);
      run({1'b0, i > 2, OP_NEG});
      ck(OFS_OPND, {16'h0, er[i]}, "neg result");
      ck(OFS_FLAGS, {16'h0, ef[i]}, "neg flags");
    end
  endtask

  task automatic t_not();
    wreg(OFS_FLAGS, 16'h0fd5);
    wreg(OFS_OPND, 16'h12a5);
    run({2'b00, OP_NOT});
    ck(OFS_OPND, 32'h125a, "inv byte");
    run({2'b01, OP_NOT});
    ck(OFS_OPND, 32'heda5, "inv word");
    ck(OFS_FLAGS, 32'h0fd5, "inv flags");
  endtask

  task automatic t_idle();
    logic [2:0] ops[4] = '{3'h0, 3'h5, 3'h6, 3'h7};
    wreg(OFS_ACC, 16'h1357);
    wreg(OFS_EXT, 16'h2468);
    for (int i = 0; i < 4; i++)
    begin
      run({2'b01, ops[i]});
      ck(OFS_OPND, 32'heda5, "idle opnd");
      ck(OFS_ACC, 32'h1357, "idle acc");
      ck(OFS_EXT, 32'h2468, "idle ext");
      ck(OFS_FLAGS, 32'h0fd5, "idle flags");
    end
  endtask

  task automatic t_copy();
    wreg(OFS_FLAGS, 16'h0005);
    mw(6'd2, 8'ha5);
    wreg(OFS_SRC, 16'd2);
    wreg(OFS_DST, 16'd10);
    run({2'b00, OP_COPY});
    mck(6'd10, 8'ha5);
    ck(OFS_SRC, 32'd3, "src up");
    ck(OFS_DST, 32'd11, "dst up");
    ck(OFS_FLAGS, 32'h0005, "copy flags");
    wreg(OFS_FLAGS, 16'h0400);
    mw(6'd20, 8'h11);
    mw(6'd21, 8'h22);
    wreg(OFS_SRC, 16'd20);
    wreg(OFS_DST, 16'd40);
    run({2'b01, OP_COPY});
    mck(6'd40, 8'h11);
    mck(6'd41, 8'h22);
    ck(OFS_SRC, 32'd18, "src down");
    ck(OFS_DST, 32'd38, "dst down");
  endtask

  task automatic t_rep();
    logic [1:0] r;
    wreg(OFS_FLAGS, 16'h0000);
    for (int i = 0; i < 8; i++)
      mw(i[5:0], 8'h31 + i[7:0]);
    wreg(OFS_SRC, 16'd0);
    wreg(OFS_DST, 16'd32);
    wreg(OFS_CNT, 16'd8);
    wr(OFS_CTRL, {27'h0, 2'b10, OP_COPY}, r);
    wr(OFS_OPND, 32'h7777, r);
    chk_resp("busy wr", RESP_SLVERR, r);
    run({2'b00, OP_IDLE});
    ck(OFS_OPND, 32'heda5, "busy opnd");
    for (int i = 0; i < 8; i++)
      mck(6'd32 + i[5:0], 8'h31 + i[7:0]);
    mck(6'd40, 8'h11);
    ck(OFS_CNT, 32'h0, "rep count");
    ck(OFS_SRC, 32'd8, "rep src");
    run({2'b10, OP_COPY});
    ck(OFS_SRC, 32'd8, "rep0 src");
    ck(OFS_DST, 32'd40, "rep0 dst");
  endtask

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_bus();
    t_mul();
    t_neg();
    t_not();
    t_idle();
    t_copy();
    t_rep();
    print_verdict();
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end
endmodule
